/* design/itw_cfg.svh */
// register map, field positions, reset values and sizes of the interval timer
`ifndef ITW_CFG_SVH
`define ITW_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ITW_ADDR_CTRL_ONE 4'h8
`define ITW_ADDR_WD_CLEAR 4'h9
`define ITW_ADDR_WD_CTRL 4'ha
`define ITW_ADDR_CTRL_TWO 4'hc
`define ITW_ADDR_IRQ_STATUS 4'hd
`define ITW_ADDR_IRQ_MASK 4'he

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ITW_C1_RESTART 3
`define ITW_C2_BYPASS 3
`define ITW_C2_CLKSEL 2
`define ITW_C2_IRQMASK 0
`define ITW_WD_LOCK_N 3
`define ITW_WD_STOP 2
`define ITW_EVT_PERIOD 0
`define ITW_EVT_WDCLR 1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ITW_RST_CTRL_ONE 4'hf
`define ITW_RST_CTRL_TWO 4'hd
`define ITW_RST_WD_CTRL 4'hf
`define ITW_RST_IRQ_MASK 2'h3

// ----------------------------------------------------------------------------
// sizes and counts
// ----------------------------------------------------------------------------
`define ITW_DIV_STAGES 14
`define ITW_SUB_PRESCALE 16
`define ITW_WD_BITS 3
`define ITW_EVT_BITS 2

`endif

/* design/itw_pkg.sv */
// types shared by the interval timer files
package itw_pkg;

    typedef logic [3:0] itw_nib_t;

    typedef enum logic [1:0] {
        ITW_WD_OFF,
        ITW_WD_RUN,
        ITW_WD_LOCKED
    } itw_wd_mode_t;

endpackage

/* design/itw_sync3.sv */
// three flip-flop pin synchroniser, output follows once stages two and three agree
`timescale 1ns/100ps

module itw_sync3 (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic pin_i,
    output logic level_o
);
    logic ff1_r;
    logic ff2_r;
    logic ff3_r;
    logic level_r;
    logic level_nxt;

    always_comb begin
        level_nxt = level_r;
        if (ff2_r == ff3_r) begin
            level_nxt = ff3_r;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ff1_r <= 1'b0;
            ff2_r <= 1'b0;
            ff3_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            ff1_r <= pin_i;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
            level_r <= level_nxt;
        end
    end

    assign level_o = level_r;

endmodule

/* design/itw_timer.sv */
// interval timer with watchdog, register port and interrupt
//
// Notes on behaviour
// - fourteen-stage divider, sub or core clock
// - selected divider tap serves as prescaler clock
// - output synchronised; held low in sleep
// - divider and interrupt keep running in sleep
// - divider runs by itself after reset
// - restart bit restarts divider if watchdog idle
// - select codes give 2..16384 division ratios
// - managed sub clock is divided by sixteen
// - bypass one uses tap, zero sub clock
// - clock select one sub, zero core clock
// - interrupt mask one blocks, zero passes
// - three-bit watchdog counter overflow resets system
// - reading clear register zeroes watchdog counter
// - unlocked: stop bit switches watchdog freely
// - lock cleared keeps watchdog on until reset
// - stop bit one stops, zero runs
// - interval codes give 512..131072 clock periods
`timescale 1ns/100ps
`include "itw_cfg.svh"

module itw_timer #(
    parameter int DIV_STAGES = `ITW_DIV_STAGES,
    parameter int WD_BITS = `ITW_WD_BITS
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] addr_i,
    input wire itw_pkg::itw_nib_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output itw_pkg::itw_nib_t rdata_o,
    input wire logic sub_clock_i,
    input wire logic subclk_from_cm_i,
    input wire logic sleep_i,
    output logic interval_output_o,
    output logic prescale_tick_o,
    output logic watchdog_reset_o,
    output logic irq_o
);
    import itw_pkg::*;

    // ------------------------------------------------------------------------
    // tap decoding
    // ------------------------------------------------------------------------
    function automatic logic [3:0] div_tap(input logic [2:0] sel);
        logic [3:0] idx;
        idx = 4'h0;
        case (sel)
            3'h0: idx = 4'h0;
            3'h1: idx = 4'h1;
            3'h2: idx = 4'h2;
            3'h3: idx = 4'h3;
            3'h4: idx = 4'h4;
            3'h5: idx = 4'h7;
            3'h6: idx = 4'ha;
            default: idx = 4'hd;
        endcase
        return idx;
    endfunction

    // one watchdog count per tap period, eight counts give the reset delay
    function automatic logic [3:0] wd_tap(input logic [1:0] sel);
        logic [3:0] idx;
        idx = 4'h0;
        case (sel)
            2'h0: idx = 4'h5;
            2'h1: idx = 4'h7;
            2'h2: idx = 4'ha;
            default: idx = 4'hd;
        endcase
        return idx;
    endfunction

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    itw_nib_t ctrl_one_r, ctrl_one_nxt;
    itw_nib_t ctrl_two_r, ctrl_two_nxt;
    itw_nib_t wd_ctrl_r, wd_ctrl_nxt;
    itw_nib_t rdata_r, rdata_nxt;
    logic [`ITW_EVT_BITS-1:0] status_r, status_nxt;
    logic [`ITW_EVT_BITS-1:0] mask_r, mask_nxt;
    logic [DIV_STAGES-1:0] div_r, div_nxt;
    logic [3:0] pre16_r, pre16_nxt;
    logic sub_prev_r, sub_prev_nxt;
    logic tap_prev_r, tap_prev_nxt;
    logic wdtap_prev_r, wdtap_prev_nxt;
    logic out_r, out_nxt;
    logic tick_r, tick_nxt;
    logic [WD_BITS-1:0] wd_cnt_r, wd_cnt_nxt;
    logic wd_rst_r, wd_rst_nxt;
    logic irq_r, irq_nxt;
    itw_wd_mode_t wd_mode_r, wd_mode_nxt;
    logic sub_lvl;
    logic sub_edge;
    logic sub_src_tick;
    logic sub_src_lvl;
    logic div_tick;
    logic tap_now;
    logic wdtap_now;
    logic period_evt;
    logic wd_evt;
    logic restart;
    logic wr_c1, wr_c2, wr_wd, wr_st, wr_mk;
    logic rd_clr;

    // ------------------------------------------------------------------------
    // sub clock pin and source selection
    // ------------------------------------------------------------------------
    itw_sync3 u_sub_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .pin_i(sub_clock_i),
        .level_o(sub_lvl)
    );

    assign sub_edge = sub_lvl & ~sub_prev_r;
    assign sub_src_tick = subclk_from_cm_i ? (sub_edge && pre16_r == 4'hf) : sub_edge;
    assign sub_src_lvl = subclk_from_cm_i ? pre16_r[3] : sub_lvl;
    assign div_tick = ctrl_two_r[`ITW_C2_CLKSEL] ? sub_src_tick : 1'b1;

    // ------------------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------------------
    always_comb begin
        wr_c1 = 1'b0;
        wr_c2 = 1'b0;
        wr_wd = 1'b0;
        wr_st = 1'b0;
        wr_mk = 1'b0;
        rd_clr = 1'b0;
        rdata_nxt = 4'h0;
        if (addr_i == `ITW_ADDR_CTRL_ONE) begin
            wr_c1 = wr_i;
            rdata_nxt = ctrl_one_r;
        end else if (addr_i == `ITW_ADDR_WD_CLEAR) begin
            rd_clr = rd_i;
        end else if (addr_i == `ITW_ADDR_WD_CTRL) begin
            wr_wd = wr_i;
            rdata_nxt = wd_ctrl_r;
        end else if (addr_i == `ITW_ADDR_CTRL_TWO) begin
            wr_c2 = wr_i;
            rdata_nxt = ctrl_two_r;
        end else if (addr_i == `ITW_ADDR_IRQ_STATUS) begin
            wr_st = wr_i;
            rdata_nxt = {2'h0, status_r};
        end else if (addr_i == `ITW_ADDR_IRQ_MASK) begin
            wr_mk = wr_i;
            rdata_nxt = {2'h0, mask_r};
        end
        if (!rd_i) begin
            rdata_nxt = 4'h0;
        end
    end

    // ------------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------------
    assign restart = wr_c1 && wdata_i[`ITW_C1_RESTART] && wd_mode_r == ITW_WD_OFF;

    always_comb begin
        ctrl_one_nxt = wr_c1 ? wdata_i : ctrl_one_r;
        ctrl_two_nxt = wr_c2 ? (wdata_i & 4'hd) : ctrl_two_r;
        wd_ctrl_nxt = wd_ctrl_r;
        if (wr_wd) begin
            wd_ctrl_nxt = wdata_i;
            if (wd_mode_r == ITW_WD_LOCKED) begin
                wd_ctrl_nxt[`ITW_WD_LOCK_N] = 1'b0;
                wd_ctrl_nxt[`ITW_WD_STOP] = wd_ctrl_r[`ITW_WD_STOP];
            end
        end
        mask_nxt = wr_mk ? wdata_i[`ITW_EVT_BITS-1:0] : mask_r;
    end

    // ------------------------------------------------------------------------
    // divider and synchronised output
    // ------------------------------------------------------------------------
    assign tap_now = div_r[div_tap(ctrl_one_r[2:0])];
    assign wdtap_now = div_r[wd_tap(wd_ctrl_r[1:0])];
    assign period_evt = tap_prev_r & ~tap_now;
    assign wd_evt = wdtap_prev_r & ~wdtap_now;

    always_comb begin
        sub_prev_nxt = sub_lvl;
        pre16_nxt = pre16_r;
        if (sub_edge && subclk_from_cm_i) begin
            pre16_nxt = pre16_r + 4'h1;
        end
        // the divider never looks at sleep, so interrupts carry on
        div_nxt = div_r;
        if (restart) begin
            div_nxt = '0;
        end else if (div_tick) begin
            div_nxt = div_r + {{(DIV_STAGES-1){1'b0}}, 1'b1};
        end
        tap_prev_nxt = restart ? 1'b0 : tap_now;
        wdtap_prev_nxt = restart ? 1'b0 : wdtap_now;
        out_nxt = ctrl_two_r[`ITW_C2_BYPASS] ? tap_now : sub_src_lvl;
        if (sleep_i) begin
            out_nxt = 1'b0;
        end
        tick_nxt = period_evt;
    end

    // ------------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------------
    always_comb begin
        wd_mode_nxt = wd_mode_r;
        case (wd_mode_r)
            ITW_WD_OFF, ITW_WD_RUN: begin
                if (wr_wd && !wdata_i[`ITW_WD_LOCK_N]) begin
                    wd_mode_nxt = ITW_WD_LOCKED;
                end else if (wr_wd) begin
                    wd_mode_nxt = wdata_i[`ITW_WD_STOP] ? ITW_WD_OFF : ITW_WD_RUN;
                end
            end
            default: begin
                wd_mode_nxt = ITW_WD_LOCKED;
            end
        endcase
        wd_cnt_nxt = wd_cnt_r;
        wd_rst_nxt = 1'b0;
        if (wd_mode_r == ITW_WD_OFF || rd_clr) begin
            wd_cnt_nxt = '0;
        end else if (wd_evt) begin
            wd_cnt_nxt = wd_cnt_r + {{(WD_BITS-1){1'b0}}, 1'b1};
            wd_rst_nxt = &wd_cnt_r;
        end
    end

    // ------------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------------
    always_comb begin
        status_nxt = status_r;
        if (wr_st) begin
            status_nxt = status_r & ~wdata_i[`ITW_EVT_BITS-1:0];
        end
        // a new event beats a clear in the same cycle
        status_nxt[`ITW_EVT_PERIOD] = status_nxt[`ITW_EVT_PERIOD] | period_evt;
        status_nxt[`ITW_EVT_WDCLR] = status_nxt[`ITW_EVT_WDCLR] | rd_clr;
        irq_nxt = (status_nxt[`ITW_EVT_PERIOD] && !mask_nxt[`ITW_EVT_PERIOD]
                   && !ctrl_two_nxt[`ITW_C2_IRQMASK])
                  || (status_nxt[`ITW_EVT_WDCLR] && !mask_nxt[`ITW_EVT_WDCLR]);
    end

    // ------------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_one_r <= `ITW_RST_CTRL_ONE;
            ctrl_two_r <= `ITW_RST_CTRL_TWO;
            wd_ctrl_r <= `ITW_RST_WD_CTRL;
            mask_r <= `ITW_RST_IRQ_MASK;
            status_r <= '0;
            rdata_r <= 4'h0;
            div_r <= '0;
            pre16_r <= 4'h0;
            sub_prev_r <= 1'b0;
            tap_prev_r <= 1'b0;
            wdtap_prev_r <= 1'b0;
            out_r <= 1'b0;
            tick_r <= 1'b0;
            wd_cnt_r <= '0;
            wd_rst_r <= 1'b0;
            irq_r <= 1'b0;
            wd_mode_r <= ITW_WD_OFF;
        end else begin
            ctrl_one_r <= ctrl_one_nxt;
            ctrl_two_r <= ctrl_two_nxt;
            wd_ctrl_r <= wd_ctrl_nxt;
            mask_r <= mask_nxt;
            status_r <= status_nxt;
            rdata_r <= rdata_nxt;
            div_r <= div_nxt;
            pre16_r <= pre16_nxt;
            sub_prev_r <= sub_prev_nxt;
            tap_prev_r <= tap_prev_nxt;
            wdtap_prev_r <= wdtap_prev_nxt;
            out_r <= out_nxt;
            tick_r <= tick_nxt;
            wd_cnt_r <= wd_cnt_nxt;
            wd_rst_r <= wd_rst_nxt;
            irq_r <= irq_nxt;
            wd_mode_r <= wd_mode_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign interval_output_o = out_r;
    assign prescale_tick_o = tick_r;
    assign watchdog_reset_o = wd_rst_r;
    assign irq_o = irq_r;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    chk_out_sleep_low: assert property (
        sleep_i |=> !interval_output_o
    ) else $error("timer output not low during sleep");

    chk_restart_clears: assert property (
        (wr_i && addr_i == `ITW_ADDR_CTRL_ONE && wdata_i[`ITW_C1_RESTART]
         && wd_mode_r == ITW_WD_OFF) |=> div_r == '0
    ) else $error("restart write did not clear divider");

    chk_core_clk_count: assert property (
        (!ctrl_two_r[`ITW_C2_CLKSEL] && !wr_i) ##1 !ctrl_two_r[`ITW_C2_CLKSEL]
        |-> div_r == $past(div_r) + 14'h1
    ) else $error("divider not counting core clock");

    chk_wd_reset_pulse: assert property (
        watchdog_reset_o |-> $past(wd_cnt_r) == 3'h7 && wd_cnt_r == 3'h0 ##1 !watchdog_reset_o
    ) else $error("watchdog reset not a single overflow pulse");

    chk_wd_clear_read: assert property (
        (rd_i && addr_i == `ITW_ADDR_WD_CLEAR) |=> wd_cnt_r == '0 && !watchdog_reset_o
    ) else $error("clear read did not zero watchdog");

    chk_lock_sticky: assert property (
        wd_mode_r == ITW_WD_LOCKED |=> wd_mode_r == ITW_WD_LOCKED [*3]
    ) else $error("locked watchdog left locked mode");

    chk_unlocked_stop: assert property (
        (wd_mode_r != ITW_WD_LOCKED && wr_i && addr_i == `ITW_ADDR_WD_CTRL
         && wdata_i[`ITW_WD_LOCK_N]) |=> (wd_mode_r == ITW_WD_OFF) == $past(wdata_i[`ITW_WD_STOP])
    ) else $error("stop bit did not switch watchdog");

    chk_irq_period: assert property (
        (period_evt && !mask_r[`ITW_EVT_PERIOD] && !ctrl_two_r[`ITW_C2_IRQMASK]
         && !wr_i) |=> irq_o && status_r[`ITW_EVT_PERIOD]
    ) else $error("unmasked period did not raise interrupt");

endmodule

/* dv/itw_sub_src.sv */
// free-running sub clock oscillator seen by the interval timer
`timescale 1ns/100ps

module itw_sub_src #(
    parameter realtime HALF_NS = 65.0
) (
    output logic sub_clock_o
);

    // ------------------------------------------------------------------------
    // oscillator
    // ------------------------------------------------------------------------
    // period of 130 ns, out of phase with the core clock on purpose
    initial begin
        sub_clock_o = 1'b0;
        #3.3;
        forever begin
            #(HALF_NS) sub_clock_o = ~sub_clock_o;
        end
    end

endmodule

/* dv/tb_top.sv */
// self-checking bench of the interval timer with watchdog
`timescale 1ns/100ps
`include "itw_cfg.svh"

module tb_top;
    import itw_pkg::*;

    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    itw_nib_t wdata_i = 4'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    itw_nib_t rdata_o;
    logic sub_clock_i;
    logic subclk_from_cm_i = 1'b0;
    logic sleep_i = 1'b0;
    logic interval_output_o, prescale_tick_o, watchdog_reset_o, irq_o;
    int n_fail = 0;
    int comparisons = 0;
    int n_wdr = 0;
    int n, n0, k;
    int tap[8] = '{1, 2, 3, 4, 5, 8, 11, 14};
    logic rd_q = 1'b0;
    logic [31:0] seed = 32'h6c6c8756;
    itw_nib_t exp_q[$];

    always #4 clk_i = ~clk_i;

    itw_sub_src src_u (.sub_clock_o(sub_clock_i));

    itw_timer dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sub_clock_i(sub_clock_i),
        .subclk_from_cm_i(subclk_from_cm_i), .sleep_i(sleep_i),
        .interval_output_o(interval_output_o), .prescale_tick_o(prescale_tick_o),
        .watchdog_reset_o(watchdog_reset_o), .irq_o(irq_o));

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input itw_nib_t d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input itw_nib_t e);
        exp_q.push_back(e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask

    function automatic logic sel(input int w);
        case (w)
            0: return prescale_tick_o;
            1: return watchdog_reset_o;
            default: return irq_o;
        endcase
    endfunction

    // counts edges until the chosen output is seen high
    task automatic wait_on(input int w, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_i);
            cnt++;
        end while (sel(w) !== 1'b1 && cnt < lim);
        if (sel(w) !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            print_verdict();
        end
    endtask

    // counts changes of the timer output over a number of clock edges
    task automatic count_toggles(input int cyc, output int cnt);
        logic prev;
        cnt = 0;
        prev = interval_output_o;
        repeat (cyc) begin
            @(posedge clk_i);
            cnt += (interval_output_o !== prev);
            prev = interval_output_o;
        end
    endtask

    // ------------------------------------------------------------------------
    // read data and watchdog reset watcher
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        rd_q <= rd_i;
        if (rd_q) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                check(rdata_o, exp_q.pop_front());
            end
        end
        if (watchdog_reset_o === 1'b1) begin
            n_wdr++;
        end
    end

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(4'h8, 4'hf);
        rd(4'ha, 4'hf);
        rd(4'hc, 4'hd);
        rd(4'hd, 4'h0);
        rd(4'he, 4'h3);
        rd(4'h9, 4'h0);
        rd(4'hd, 4'h2);
        wr(4'hd, 4'h3);
        rd(4'hd, 4'h0);
        k = xs() % 8;
        wr(k[3:0], itw_nib_t'(xs()));
        rd(k[3:0], 4'h0);
        // sub clock feeds the divider, ratio two: two sub clock periods of 130 ns
        wr(4'hc, 4'hc);
        wr(4'h8, 4'h8);
        wait_on(0, 200, n);
        wait_on(0, 200, n);
        check(n >= 30 && n <= 35, 1);
        // managed sub clock is cut by sixteen: ratio two spans 32 sub periods
        subclk_from_cm_i <= 1'b1;
        wr(4'h8, 4'h8);
        wait_on(0, 600, n);
        wait_on(0, 600, n);
        check(n >= 515 && n <= 525, 1);
        subclk_from_cm_i <= 1'b0;
        wr(4'hc, 4'h8);
        // restart bit low: the divider keeps its phase, next tick 32 after the last
        wr(4'h8, 4'h4);
        wait_on(0, 40, n);
        wait_on(0, 40, n);
        wr(4'h8, 4'h4);
        wait_on(0, 40, n);
        check(n, 30);
        for (int c = 0; c < 8; c++) begin
            wr(4'h8, 4'h8 | c[3:0]);
            wait_on(0, 20000, n);
            wait_on(0, 20000, n);
            check(n, 1 << tap[c]);
        end
        // interrupt: code 7 restarted so no period ends while checking
        wr(4'he, 4'h0);
        repeat (2) @(posedge clk_i);
        check(irq_o, 1'b1);
        wr(4'hc, 4'h9);
        repeat (2) @(posedge clk_i);
        check(irq_o, 1'b0);
        wr(4'hc, 4'h8);
        wr(4'h8, 4'hf);
        wr(4'hd, 4'h3);
        repeat (2) @(posedge clk_i);
        check(irq_o, 1'b0);
        wait_on(2, 16400, n);
        check(n > 16000, 1);
        wr(4'he, 4'h3);
        // sleep stops the output but not the divider
        wr(4'h8, 4'h8);
        sleep_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        k = 0;
        repeat (40) begin
            @(posedge clk_i);
            k += (interval_output_o !== 1'b0);
        end
        check(k, 0);
        wait_on(0, 10, n);
        sleep_i <= 1'b0;
        // bypass on: output follows the tap, toggling every cycle at ratio two
        repeat (3) @(posedge clk_i);
        count_toggles(16, k);
        check(k, 16);
        // bypass off: output follows the slow sub clock, not the fast tap
        wr(4'hc, 4'h0);
        repeat (4) @(posedge clk_i);
        count_toggles(64, k);
        check(k >= 6 && k <= 10, 1);
        // watchdog enabled by software at start-up
        wr(4'ha, 4'h8);
        wait_on(1, 600, n);
        check(n <= 520, 1);
        wait_on(1, 600, n);
        check(n, 512);
        wr(4'ha, 4'h9);
        wait_on(1, 2100, n);
        wait_on(1, 2100, n);
        check(n, 2048);
        wr(4'ha, 4'h8);
        n0 = n_wdr;
        repeat (5) begin
            rd(4'h9, 4'h0);
            repeat (100 + xs() % 300) @(posedge clk_i);
        end
        check(n_wdr, n0);
        wr(4'ha, 4'hc);
        n0 = n_wdr;
        repeat (1200) @(posedge clk_i);
        check(n_wdr, n0);
        wr(4'ha, 4'h8);
        wait_on(1, 600, n);
        wr(4'ha, 4'h0);
        wr(4'ha, 4'hc);
        rd(4'ha, 4'h0);
        wait_on(1, 600, n);
        nrst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(4'ha, 4'hf);
        // no restart write: the divider must already be running
        wr(4'hc, 4'h8);
        wr(4'h8, 4'h0);
        wait_on(0, 10, n);
        repeat (3) @(posedge clk_i);
        print_verdict();
    end

endmodule
